// [dv/pdcp_periph_model.sv]
// Purpose: peripheral side of one dma direction
// Assumes: a transfer is finished only while the request is valid
// Notes:   gap_i idle cycles between finished transfers
module pdcp_periph_model (
   // clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   // bench control
   input  wire logic            go_i,
   input  wire logic [1:0]      gap_i,
   // dma side
   input  pdcp_pkg::pdcp_req_t  req_i,
   output logic                 trig_o,
   output logic                 done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_q;
   assign trig_o = go_i;
   // never answers an idle request
   assign done_o = req_i.valid && (wait_q == gap_i);
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         wait_q <= 2'h0;
      else if (done_o || !req_i.valid)
         wait_q <= 2'h0;
      else
         wait_q <= wait_q + 2'h1;
   end
endmodule

// [dv/tb_top.sv]
// Purpose: self-checking bench of the dma pair register block
// Assumes: one outstanding axi access at a time
// Notes:   map and enables first, then chained rx and masked tx runs
`include "pdcp_defines.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} pdcp_row_t;
   logic                 clk, rst, awv, wv, bry, arv, rry, rx_go, tx_go;
   logic [11:0]          awa, ara;
   logic [31:0]          wd, v;
   logic [3:0]           ws;
   logic [1:0]           rsp;
   logic                 awr, wr, bv, arr, rv, irq;
   logic                 rx_end, rx_all, tx_end, tx_all, rx_trig, rx_done, tx_trig, tx_done;
   logic [1:0]           br, rr;
   logic [31:0]          rd;
   pdcp_pkg::pdcp_req_t  rx_req, tx_req;
   pdcp_pkg::pdcp_size_t rx_sz, tx_sz;
   int                   err_total, total_checks;
   pdcp_row_t rows [11] = '{
      '{`PDCP_RPR, 32'hffff_ffff, 32'hffff_ffff, `PDCP_OKAY},
      '{`PDCP_RCR, 32'hffff_ffff, 32'h0000_ffff, `PDCP_OKAY},
      '{`PDCP_TPR, 32'ha5a5_a5a5, 32'ha5a5_a5a5, `PDCP_OKAY},
      '{`PDCP_TCR, 32'h1234_5678, 32'h0000_5678, `PDCP_OKAY},
      '{`PDCP_RNPR, 32'h5a5a_5a5a, 32'h5a5a_5a5a, `PDCP_OKAY},
      '{`PDCP_RNCR, 32'hffff_0001, 32'h0000_0001, `PDCP_OKAY},
      '{`PDCP_TNPR, 32'h0f0f_0f0f, 32'h0f0f_0f0f, `PDCP_OKAY},
      '{`PDCP_TNCR, 32'h0000_ffff, 32'h0000_ffff, `PDCP_OKAY},
      '{`PDCP_PTCR, 32'h0000_0000, 32'h0000_0000, `PDCP_OKAY},
      '{`PDCP_PTSR, 32'hffff_ffff, 32'h0000_0000, `PDCP_OKAY},
      '{12'h200, 32'h1234_5678, 32'h0000_0000, `PDCP_SLVERR}};
   logic [31:0] cmd [9] = '{32'h003, 32'h001, 32'h000, 32'h002, 32'h100,
                            32'h000, 32'h300, 32'h100, 32'h200};
   logic [31:0] sts [9] = '{32'h000, 32'h001, 32'h001, 32'h000, 32'h100,
                            32'h100, 32'h000, 32'h100, 32'h000};

   pdcp_top i_dut (
      .REF_CLK_I(clk), .RST_I(rst),
      .S_AWADDR_I(awa), .S_AWVALID_I(awv), .S_AWREADY_O(awr),
      .S_WDATA_I(wd), .S_WSTRB_I(ws), .S_WVALID_I(wv), .S_WREADY_O(wr),
      .S_BRESP_O(br), .S_BVALID_O(bv), .S_BREADY_I(bry),
      .S_ARADDR_I(ara), .S_ARVALID_I(arv), .S_ARREADY_O(arr),
      .S_RDATA_O(rd), .S_RRESP_O(rr), .S_RVALID_O(rv), .S_RREADY_I(rry),
      .RX_TRIG_I(rx_trig), .RX_DONE_I(rx_done), .RX_SIZE_I(rx_sz), .RX_REQ_O(rx_req),
      .RX_END_O(rx_end), .RX_ALL_O(rx_all),
      .TX_TRIG_I(tx_trig), .TX_DONE_I(tx_done), .TX_SIZE_I(tx_sz), .TX_REQ_O(tx_req),
      .TX_END_O(tx_end), .TX_ALL_O(tx_all),
      .IRQ_O(irq));
   pdcp_periph_model i_rx (.clk_i(clk), .rst_i(rst), .go_i(rx_go), .gap_i(2'h0),
      .req_i(rx_req), .trig_o(rx_trig), .done_o(rx_done));
   pdcp_periph_model i_tx (.clk_i(clk), .rst_i(rst), .go_i(tx_go), .gap_i(2'h2),
      .req_i(tx_req), .trig_o(tx_trig), .done_o(tx_done));

   always #2.5 clk = ~clk;

   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (!(ta && tw))
      begin
         @(posedge clk);
         if (awr && !ta)
            awv <= 1'b0;
         if (wr && !tw)
            wv <= 1'b0;
         ta = ta | awr;
         tw = tw | wr;
      end
      do
         @(posedge clk);
      while (!bv);
      bry <= 1'b0;
      chk("bresp", {30'h0, r}, {30'h0, br});
   endtask

   task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do
         @(posedge clk);
      while (!arr);
      arv <= 1'b0;
      do
         @(posedge clk);
      while (!rv);
      rry <= 1'b0;
      d = rd;
      r = rr;
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      axr(a, v, rsp);
      chk($sformatf("rdata %h", a), e, v);
      chk($sformatf("rresp %h", a), {30'h0, r}, {30'h0, rsp});
   endtask

   task automatic wait_all(input logic rx);
      while (!(rx ? rx_all : tx_all))
         @(posedge clk);
      repeat (2) @(posedge clk);
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      give_verdict();
   end

   initial
   begin
      {clk, awv, wv, bry, arv, rry, rx_go, tx_go} = '0;
      {awa, ara, wd} = '0;
      ws = 4'hf;
      rx_sz = pdcp_pkg::PDCP_HALF;
      tx_sz = pdcp_pkg::PDCP_WORD;
      rst = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      chk("rx_all at reset", 32'h1, {31'h0, rx_all});
      for (int i = 0; i < 10; i++)
         rdc(12'(12'h100 + i * 4), 32'h0, `PDCP_OKAY);
      foreach (rows[i])
      begin
         axw(rows[i].a, rows[i].d, rows[i].r);
         rdc(rows[i].a, rows[i].e, rows[i].r);
      end
      foreach (cmd[i])
      begin
         axw(`PDCP_PTCR, cmd[i], `PDCP_OKAY);
         rdc(`PDCP_PTSR, sts[i], `PDCP_OKAY);
      end
      // chained rx run, half words, prompt peripheral
      axw(`PDCP_RPR, 32'h1000, `PDCP_OKAY);
      axw(`PDCP_RCR, 32'h3, `PDCP_OKAY);
      axw(`PDCP_RNPR, 32'h2000, `PDCP_OKAY);
      axw(`PDCP_RNCR, 32'h2, `PDCP_OKAY);
      axw(`PDCP_IMR, 32'h1, `PDCP_OKAY);
      axr(`PDCP_ISR, v, rsp);
      rx_go <= 1'b1;
      axw(`PDCP_PTCR, 32'h1, `PDCP_OKAY);
      wait_all(1'b1);
      rdc(`PDCP_RPR, 32'h2004, `PDCP_OKAY);
      rdc(`PDCP_RCR, 32'h0, `PDCP_OKAY);
      rdc(`PDCP_RNCR, 32'h0, `PDCP_OKAY);
      rdc(`PDCP_PTSR, 32'h1, `PDCP_OKAY);
      chk("rx_end", 32'h1, {31'h0, rx_end});
      chk("irq raised", 32'h1, {31'h0, irq});
      rdc(`PDCP_ISR, 32'h3, `PDCP_OKAY);
      chk("irq cleared", 32'h0, {31'h0, irq});
      // counter write clears the end flag, then one byte transfer
      rx_go <= 1'b0;
      rx_sz <= pdcp_pkg::PDCP_BYTE;
      axw(`PDCP_RCR, 32'h1, `PDCP_OKAY);
      chk("rx_end after write", 32'h0, {31'h0, rx_end});
      chk("rx_all after write", 32'h0, {31'h0, rx_all});
      rx_go <= 1'b1;
      wait_all(1'b1);
      rdc(`PDCP_RPR, 32'h2005, `PDCP_OKAY);
      rdc(`PDCP_ISR, 32'h3, `PDCP_OKAY);
      // tx run, words, slow peripheral, events masked
      axw(`PDCP_TPR, 32'h3000, `PDCP_OKAY);
      axw(`PDCP_TCR, 32'h2, `PDCP_OKAY);
      axw(`PDCP_TNCR, 32'h0, `PDCP_OKAY);
      tx_go <= 1'b1;
      axw(`PDCP_PTCR, 32'h100, `PDCP_OKAY);
      wait_all(1'b0);
      rdc(`PDCP_TPR, 32'h3008, `PDCP_OKAY);
      chk("tx req addr", 32'h3008, tx_req.addr);
      chk("tx req stops", 32'h0, {31'h0, tx_req.valid});
      chk("tx_end", 32'h1, {31'h0, tx_end});
      chk("tx_all", 32'h1, {31'h0, tx_all});
      chk("irq masked", 32'h0, {31'h0, irq});
      rdc(`PDCP_PTSR, 32'h101, `PDCP_OKAY);
      rdc(`PDCP_ISR, 32'hc, `PDCP_OKAY);
      // second reset after both runs have finished
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rdc(`PDCP_RPR, 32'h0, `PDCP_OKAY);
      rdc(`PDCP_PTSR, 32'h0, `PDCP_OKAY);
      chk("rx_all after reset", 32'h1, {31'h0, rx_all});
      give_verdict();
   end
endmodule

// [rtl/pdcp_chan.sv]
// Purpose: one direction: pointer, counter, next pair, end flags
// Assumes: done_i pulses once per finished transfer while req valid
// Notes:   software writes win over hardware updates of the same register
`include "pdcp_defines.svh"
module pdcp_chan #(
   parameter int CW = `PDCP_CNTW
) (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // control from the register file
   input  wire logic               en_i,
   input  wire logic [3:0]         wr_i,
   input  wire logic [31:0]        wdata_i,
   // peripheral side
   input  wire logic               trig_i,
   input  wire logic               done_i,
   input  pdcp_pkg::pdcp_size_t    size_i,
   output pdcp_pkg::pdcp_req_t     req_o,
   // state
   output logic [31:0]             ptr_o,
   output logic [31:0]             nptr_o,
   output logic [CW-1:0]           cnt_o,
   output logic [CW-1:0]           ncnt_o,
   output logic                    end_o,
   output logic                    all_o,
   output logic                    end_evt_o
);
   logic [31:0]   ptr_q;
   logic [31:0]   nptr_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] ncnt_q;
   logic          end_q;
   logic [31:0]   inc;
   logic          step;
   logic          last;
   logic          reload;

   always_comb
   begin
      case (size_i)
         pdcp_pkg::PDCP_BYTE: inc = `PDCP_INC_B;
         pdcp_pkg::PDCP_HALF: inc = `PDCP_INC_H;
         default:             inc = `PDCP_INC_W;
      endcase
   end

   assign req_o.valid = en_i && trig_i && (cnt_q != '0);
   assign req_o.size  = size_i;
   assign req_o.addr  = ptr_q;
   assign step   = done_i && req_o.valid;
   assign last   = step && (cnt_q == CW'(1)) && !wr_i[`PDCP_WC];
   assign reload = last && (ncnt_q != '0);

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ptr_q <= '0;
      else if (wr_i[`PDCP_WP])
         ptr_q <= wdata_i;
      else if (reload)
         ptr_q <= nptr_q;
      else if (step)
         ptr_q <= ptr_q + inc;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         cnt_q <= '0;
      else if (wr_i[`PDCP_WC])
         cnt_q <= wdata_i[CW-1:0];
      else if (reload)
         cnt_q <= ncnt_q;
      else if (step)
         cnt_q <= cnt_q - CW'(1);
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         nptr_q <= '0;
      else if (wr_i[`PDCP_WNP])
         nptr_q <= wdata_i;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ncnt_q <= '0;
      else if (wr_i[`PDCP_WNC])
         ncnt_q <= wdata_i[CW-1:0];
      else if (reload)
         ncnt_q <= '0;
   end

   // set wins over the clear by a next counter write; a current counter write blocks the set
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         end_q <= 1'b0;
      else
         end_q <= last | (end_q & ~(wr_i[`PDCP_WC] | wr_i[`PDCP_WNC]));
   end

   assign ptr_o     = ptr_q;
   assign nptr_o    = nptr_q;
   assign cnt_o     = cnt_q;
   assign ncnt_o    = ncnt_q;
   assign end_o     = end_q;
   assign all_o     = (cnt_q == '0) && (ncnt_q == '0);
   assign end_evt_o = last;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_cnt_step: assert property (step && !last && !wr_i[`PDCP_WC]
      |=> cnt_q == $past(cnt_q) - CW'(1)) else $error("counter did not step");
   chk_ptr_step: assert property (step && !reload && !wr_i[`PDCP_WP]
      |=> ptr_q == $past(ptr_q) + $past(inc)) else $error("pointer did not advance");
   chk_chain_load: assert property (reload && !wr_i[`PDCP_WNC]
      |=> cnt_q == $past(ncnt_q) && ncnt_q == '0) else $error("next buffer not loaded");
   chk_zero_stop: assert property (cnt_q == '0 |-> !req_o.valid)
      else $error("request with zero count");
   chk_end_clear: assert property ((wr_i[`PDCP_WC] || wr_i[`PDCP_WNC]) && !last
      |=> !end_q) else $error("end flag not cleared");
   chk_end_set: assert property (last |=> end_q) else $error("end flag missed");
endmodule

// [rtl/pdcp_defines.svh]
// Purpose: register map, field positions and widths of the dma pair
// Assumes: 32-bit AXI4-Lite data, byte addresses within the window
// Notes:   included by pdcp_chan, pdcp_top and the bench
`ifndef PDCP_DEFINES_SVH
`define PDCP_DEFINES_SVH
`define PDCP_AW      12
`define PDCP_CNTW    16
`define PDCP_RPR     12'h100
`define PDCP_RCR     12'h104
`define PDCP_TPR     12'h108
`define PDCP_TCR     12'h10c
`define PDCP_RNPR    12'h110
`define PDCP_RNCR    12'h114
`define PDCP_TNPR    12'h118
`define PDCP_TNCR    12'h11c
`define PDCP_PTCR    12'h120
`define PDCP_PTSR    12'h124
`define PDCP_ISR     12'h128
`define PDCP_IMR     12'h12c
`define PDCP_RXON    0
`define PDCP_RXOFF   1
`define PDCP_TXON    8
`define PDCP_TXOFF   9
`define PDCP_WP      0
`define PDCP_WC      1
`define PDCP_WNP     2
`define PDCP_WNC     3
`define PDCP_IRQW    4
`define PDCP_I_RXEND 0
`define PDCP_I_RXALL 1
`define PDCP_I_TXEND 2
`define PDCP_I_TXALL 3
`define PDCP_INC_B   32'h0000_0001
`define PDCP_INC_H   32'h0000_0002
`define PDCP_INC_W   32'h0000_0004
`define PDCP_OKAY    2'b00
`define PDCP_SLVERR  2'b10
`endif

// [rtl/pdcp_pkg.sv]
// Purpose: shared types of the dma pair
// Assumes: nothing
// Notes:   constants live in pdcp_defines.svh
package pdcp_pkg;
   typedef enum logic [1:0] {PDCP_BYTE, PDCP_HALF, PDCP_WORD} pdcp_size_t;
   typedef struct packed {
      logic       valid;
      pdcp_size_t size;
      logic [31:0] addr;
   } pdcp_req_t;
endpackage

// [rtl/pdcp_top.sv]
// Purpose: AXI4-Lite register file and control of an rx/tx dma pair
// Assumes: peripheral on the same clock; one transfer finishes per done pulse
// Notes:   read of the interrupt status clears it
// Behaviour
// - rx pointer holds a 32-bit address, read and write by software.
// - rx counter holds 16-bit remaining transfers, upper bits unused.
// - tx pointer holds the 32-bit address of the next fetched item.
// - tx counter holds 16-bit remaining count; transfers stop at zero.
// - rx next pointer holds the following rx buffer address.
// - rx next counter holds the following rx buffer size.
// - tx next pointer holds the following tx buffer address.
// - tx next counter holds the following tx buffer size.
// - command bit 0 enables rx requests unless bit 1 also set.
// - command bit 1 disables rx requests; zero changes nothing.
// - command bit 8 enables tx requests unless bit 9 also set; zero changes nothing.
// - command bit 9 disables tx requests; zero changes nothing.
// - status bit 0 reads the rx enable state.
// - status bit 8 reads the tx enable state.
// - each transfer advances pointer by 1, 2 or 4 and decrements counter, unless it is a last transfer that loads the next pair.
// - at zero load next pair, clear next counter, stay enabled.
// - end flag on the last transfer of each buffer, chained or not; all-done flag when both counters zero.
// - writing current counter, or next counter outside a last transfer, clears that direction's end flag.
`include "pdcp_defines.svh"
module pdcp_top #(
   parameter int AW = `PDCP_AW
) (
   // clock and reset
   input  wire logic               REF_CLK_I,
   input  wire logic               RST_I,
   // axi4-lite write address
   input  wire logic [AW-1:0]      S_AWADDR_I,
   input  wire logic               S_AWVALID_I,
   output logic                    S_AWREADY_O,
   // axi4-lite write data
   input  wire logic [31:0]        S_WDATA_I,
   input  wire logic [3:0]         S_WSTRB_I,
   input  wire logic               S_WVALID_I,
   output logic                    S_WREADY_O,
   // axi4-lite write response
   output logic [1:0]              S_BRESP_O,
   output logic                    S_BVALID_O,
   input  wire logic               S_BREADY_I,
   // axi4-lite read address
   input  wire logic [AW-1:0]      S_ARADDR_I,
   input  wire logic               S_ARVALID_I,
   output logic                    S_ARREADY_O,
   // axi4-lite read data
   output logic [31:0]             S_RDATA_O,
   output logic [1:0]              S_RRESP_O,
   output logic                    S_RVALID_O,
   input  wire logic               S_RREADY_I,
   // receive peripheral side
   input  wire logic               RX_TRIG_I,
   input  wire logic               RX_DONE_I,
   input  pdcp_pkg::pdcp_size_t    RX_SIZE_I,
   output pdcp_pkg::pdcp_req_t     RX_REQ_O,
   output logic                    RX_END_O,
   output logic                    RX_ALL_O,
   // transmit peripheral side
   input  wire logic               TX_TRIG_I,
   input  wire logic               TX_DONE_I,
   input  pdcp_pkg::pdcp_size_t    TX_SIZE_I,
   output pdcp_pkg::pdcp_req_t     TX_REQ_O,
   output logic                    TX_END_O,
   output logic                    TX_ALL_O,
   // interrupt
   output logic                    IRQ_O
);
   localparam int CW = `PDCP_CNTW;

   logic [11:0]           awaddr_q;
   logic                  aw_full_q;
   logic [31:0]           wdata_q;
   logic [3:0]            wstrb_q;
   logic                  w_full_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   logic                  rvalid_q;
   logic [1:0]            rresp_q;
   logic [31:0]           rdata_q;
   logic                  rx_en_q;
   logic                  tx_en_q;
   logic [`PDCP_IRQW-1:0] sts_q;
   logic [`PDCP_IRQW-1:0] mask_q;
   logic                  rx_all_q;
   logic                  tx_all_q;
   logic                  wr_go;
   logic                  rd_go;
   logic [11:0]           raddr;
   logic [31:0]           wmask;
   logic [31:0]           wmerged;
   logic [31:0]           cmd;
   logic [3:0]            rx_wr;
   logic [3:0]            tx_wr;
   logic [`PDCP_IRQW-1:0] sts_set;
   logic [31:0]           rx_ptr;
   logic [31:0]           rx_nptr;
   logic [CW-1:0]         rx_cnt;
   logic [CW-1:0]         rx_ncnt;
   logic                  rx_evt;
   logic [31:0]           tx_ptr;
   logic [31:0]           tx_nptr;
   logic [CW-1:0]         tx_cnt;
   logic [CW-1:0]         tx_ncnt;
   logic                  tx_evt;

   // register contents as seen by a read
   function automatic logic [31:0] pdcp_rd(input logic [11:0] a);
      case (a)
         `PDCP_RPR:  pdcp_rd = rx_ptr;
         `PDCP_RCR:  pdcp_rd = 32'(rx_cnt);
         `PDCP_TPR:  pdcp_rd = tx_ptr;
         `PDCP_TCR:  pdcp_rd = 32'(tx_cnt);
         `PDCP_RNPR: pdcp_rd = rx_nptr;
         `PDCP_RNCR: pdcp_rd = 32'(rx_ncnt);
         `PDCP_TNPR: pdcp_rd = tx_nptr;
         `PDCP_TNCR: pdcp_rd = 32'(tx_ncnt);
         `PDCP_PTSR:
         begin
            pdcp_rd = '0;
            pdcp_rd[`PDCP_RXON] = rx_en_q;
            pdcp_rd[`PDCP_TXON] = tx_en_q;
         end
         `PDCP_ISR:  pdcp_rd = 32'(sts_q);
         `PDCP_IMR:  pdcp_rd = 32'(mask_q);
         default:    pdcp_rd = '0;
      endcase
   endfunction

   function automatic logic pdcp_mapped(input logic [11:0] a);
      pdcp_mapped = (a >= `PDCP_RPR) && (a <= `PDCP_IMR);
   endfunction

   // word-aligned addresses inside the 4 KiB window
   assign raddr = {S_ARADDR_I[11:2], 2'b00};

   // write channel capture
   assign S_AWREADY_O = !aw_full_q;
   assign S_WREADY_O  = !w_full_q;
   assign wr_go       = aw_full_q && w_full_q && !bvalid_q;

   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         aw_full_q <= 1'b0;
         awaddr_q  <= '0;
      end
      else if (S_AWVALID_I && !aw_full_q)
      begin
         aw_full_q <= 1'b1;
         awaddr_q  <= {S_AWADDR_I[11:2], 2'b00};
      end
      else if (wr_go)
         aw_full_q <= 1'b0;
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         w_full_q <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end
      else if (S_WVALID_I && !w_full_q)
      begin
         w_full_q <= 1'b1;
         wdata_q  <= S_WDATA_I;
         wstrb_q  <= S_WSTRB_I;
      end
      else if (wr_go)
         w_full_q <= 1'b0;
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= `PDCP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= pdcp_mapped(awaddr_q) ? `PDCP_OKAY : `PDCP_SLVERR;
      end
      else if (S_BREADY_I)
         bvalid_q <= 1'b0;
   end

   assign S_BVALID_O = bvalid_q;
   assign S_BRESP_O  = bresp_q;

   // byte lanes merged into the old value
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_lane
         assign wmask[8*g +: 8] = {8{wstrb_q[g]}};
      end
   endgenerate

   assign wmerged = (pdcp_rd(awaddr_q) & ~wmask) | (wdata_q & wmask);
   assign cmd     = (awaddr_q == `PDCP_PTCR && wr_go) ? (wdata_q & wmask) : '0;

   assign rx_wr[`PDCP_WP]  = wr_go && awaddr_q == `PDCP_RPR;
   assign rx_wr[`PDCP_WC]  = wr_go && awaddr_q == `PDCP_RCR;
   assign rx_wr[`PDCP_WNP] = wr_go && awaddr_q == `PDCP_RNPR;
   assign rx_wr[`PDCP_WNC] = wr_go && awaddr_q == `PDCP_RNCR;
   assign tx_wr[`PDCP_WP]  = wr_go && awaddr_q == `PDCP_TPR;
   assign tx_wr[`PDCP_WC]  = wr_go && awaddr_q == `PDCP_TCR;
   assign tx_wr[`PDCP_WNP] = wr_go && awaddr_q == `PDCP_TNPR;
   assign tx_wr[`PDCP_WNC] = wr_go && awaddr_q == `PDCP_TNCR;

   // request enables; disable has precedence in both directions
   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
         rx_en_q <= 1'b0;
      else if (cmd[`PDCP_RXOFF])
         rx_en_q <= 1'b0;
      else if (cmd[`PDCP_RXON])
         rx_en_q <= 1'b1;
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
         tx_en_q <= 1'b0;
      else if (cmd[`PDCP_TXOFF])
         tx_en_q <= 1'b0;
      else if (cmd[`PDCP_TXON])
         tx_en_q <= 1'b1;
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
         mask_q <= '0;
      else if (wr_go && awaddr_q == `PDCP_IMR)
         mask_q <= wmerged[`PDCP_IRQW-1:0];
   end

   // read channel
   assign S_ARREADY_O = !rvalid_q;
   assign rd_go       = S_ARVALID_I && !rvalid_q;

   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         rvalid_q <= 1'b0;
         rresp_q  <= `PDCP_OKAY;
         rdata_q  <= '0;
      end
      else if (rd_go)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= pdcp_mapped(raddr) ? `PDCP_OKAY : `PDCP_SLVERR;
         rdata_q  <= pdcp_rd(raddr);
      end
      else if (S_RREADY_I)
         rvalid_q <= 1'b0;
   end

   assign S_RVALID_O = rvalid_q;
   assign S_RRESP_O  = rresp_q;
   assign S_RDATA_O  = rdata_q;

   // the two channels
   pdcp_chan #(.CW(CW)) u_rx (
      .clk_i     (REF_CLK_I),
      .rst_i     (RST_I),
      .en_i      (rx_en_q),
      .wr_i      (rx_wr),
      .wdata_i   (wmerged),
      .trig_i    (RX_TRIG_I),
      .done_i    (RX_DONE_I),
      .size_i    (RX_SIZE_I),
      .req_o     (RX_REQ_O),
      .ptr_o     (rx_ptr),
      .nptr_o    (rx_nptr),
      .cnt_o     (rx_cnt),
      .ncnt_o    (rx_ncnt),
      .end_o     (RX_END_O),
      .all_o     (RX_ALL_O),
      .end_evt_o (rx_evt)
   );

   pdcp_chan #(.CW(CW)) u_tx (
      .clk_i     (REF_CLK_I),
      .rst_i     (RST_I),
      .en_i      (tx_en_q),
      .wr_i      (tx_wr),
      .wdata_i   (wmerged),
      .trig_i    (TX_TRIG_I),
      .done_i    (TX_DONE_I),
      .size_i    (TX_SIZE_I),
      .req_o     (TX_REQ_O),
      .ptr_o     (tx_ptr),
      .nptr_o    (tx_nptr),
      .cnt_o     (tx_cnt),
      .ncnt_o    (tx_ncnt),
      .end_o     (TX_END_O),
      .all_o     (TX_ALL_O),
      .end_evt_o (tx_evt)
   );

   // sticky events; all-done counts on its rising edge
   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         rx_all_q <= 1'b1;
         tx_all_q <= 1'b1;
      end
      else
      begin
         rx_all_q <= RX_ALL_O;
         tx_all_q <= TX_ALL_O;
      end
   end

   assign sts_set[`PDCP_I_RXEND] = rx_evt;
   assign sts_set[`PDCP_I_RXALL] = RX_ALL_O && !rx_all_q;
   assign sts_set[`PDCP_I_TXEND] = tx_evt;
   assign sts_set[`PDCP_I_TXALL] = TX_ALL_O && !tx_all_q;

   // set wins over the clear by a read
   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
         sts_q <= '0;
      else if (rd_go && raddr == `PDCP_ISR)
         sts_q <= sts_set;
      else
         sts_q <= sts_q | sts_set;
   end

   assign IRQ_O = |(sts_q & mask_q);

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);

   chk_rx_enable: assert property (cmd[`PDCP_RXON] && !cmd[`PDCP_RXOFF]
      |=> rx_en_q) else $error("rx not enabled");
   chk_rx_disable: assert property (cmd[`PDCP_RXOFF] |=> !rx_en_q)
      else $error("rx not disabled");
   chk_tx_enable: assert property (cmd[`PDCP_TXON] && !cmd[`PDCP_TXOFF]
      |=> tx_en_q) else $error("tx not enabled");
   chk_tx_disable: assert property (cmd[`PDCP_TXOFF] |=> !tx_en_q)
      else $error("tx not disabled");
   chk_en_hold: assert property (!wr_go |=> $stable(rx_en_q) && $stable(tx_en_q))
      else $error("enable changed without command");
   chk_state_read: assert property (rd_go && raddr == `PDCP_PTSR
      |=> S_RDATA_O[`PDCP_RXON] == $past(rx_en_q) && S_RDATA_O[`PDCP_TXON] == $past(tx_en_q))
      else $error("enable state misread");
   chk_cnt_upper: assert property (rd_go && raddr == `PDCP_RCR
      |=> S_RDATA_O[31:CW] == '0) else $error("counter upper bits set");
   chk_wr_answer: assert property (wr_go |=> S_BVALID_O) else $error("no write answer");
   chk_irq_level: assert property (sts_set != '0 |=> ##[0:1] (sts_q != '0))
      else $error("event lost");

   cov_rx_chain: cover property (u_rx.reload);
   cov_tx_all: cover property (sts_set[`PDCP_I_TXALL]);
   cov_irq: cover property (IRQ_O ##1 !IRQ_O);
   cov_both_cmd: cover property (cmd[`PDCP_TXON] && cmd[`PDCP_TXOFF]);
endmodule
